// >>> src/acrb_config_bank.sv
`timescale 1ns/100ps

module acrb_config_bank
    import acrb_pkg::*;
#(
    parameter int DATA_W = 14
) (
    input  wire logic              core_clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              reg_wr_en_in,
    input  wire logic              reg_rd_en_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              pdwn_pin_in,
    input  wire logic [DATA_W-1:0] ch_a_sample_in,
    input  wire logic [DATA_W-1:0] ch_b_sample_in,
    output      logic [7:0]        reg_rdata_out,
    output      logic              reg_rdata_valid_out,
    output      logic              ch_a_pdwn_out,
    output      logic              ch_b_pdwn_out,
    output      logic              ch_a_stby_out,
    output      logic              ch_b_stby_out,
    output      logic              dcs_active_out,
    output      logic [2:0]        clk_div_sel_out,
    output      logic [2:0]        clk_div_phase_out,
    output      logic              dco_invert_out,
    output      logic              lvds_sel_out,
    output      logic              drive_sel_out,
    output      logic              ch_a_oe_n_out,
    output      logic              ch_b_oe_n_out,
    output      logic [DATA_W-1:0] ch_a_data_out,
    output      logic [DATA_W-1:0] ch_b_data_out
);

    initial begin
        if (DATA_W < 8 || DATA_W > 2 * SHORT_LEN) begin
            $error("acrb_config_bank: DATA_W out of range");
        end
    end

    localparam int NCH = 2;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]          pwr_g;
        logic [7:0]          clk;
        logic [7:0]          div;
        logic [7:0]          out_g;
        logic [7:0]          phase;
        logic [NCH-1:0][7:0] pwr_l;
        logic [NCH-1:0][7:0] test;
        logic [NCH-1:0][7:0] built_in_self_test;
        logic [NCH-1:0][7:0] offs;
        logic [NCH-1:0][7:0] out_l;
    } acrb_cfg_t;

    typedef struct packed {
        logic [7:0]                chan_sel;
        acrb_cfg_t                 sh;
        acrb_cfg_t                 act;
        logic                      pin_meta;
        logic                      pin_sync;
        logic [7:0]                rdata;
        logic                      rvalid;
        logic [NCH-1:0]            pdwn;
        logic [NCH-1:0]            stby;
        logic                      dcs;
        logic [2:0]                div_sel;
        logic [2:0]                div_phase;
        logic                      dco_inv;
        logic                      lvds;
        logic                      drive;
        logic [NCH-1:0]            oe_n;
        logic [NCH-1:0][DATA_W-1:0] data;
    } acrb_state_t;

    localparam acrb_cfg_t CFG_RST = '{
        pwr_g: RST_ZERO, clk: RST_GLOBAL_CLK, div: RST_ZERO, out_g: RST_ZERO,
        phase: RST_ZERO, pwr_l: '0, test: '0, built_in_self_test: '0, offs: '0, out_l: '0
    };

    acrb_state_t                st_r;
    acrb_state_t                st_nxt;
    logic [NCH-1:0][DATA_W-1:0] pattern;
    logic [NCH-1:0][DATA_W-1:0] sample;

    assign sample[0] = ch_a_sample_in;
    assign sample[1] = ch_b_sample_in;

    // ****************************************************************
    // Address decode, shared by write and read paths
    // ****************************************************************
    function automatic acrb_reg_t reg_of(input logic [ADDR_W-1:0] addr);
        case (addr)
            ADDR_CHAN_INDEX: reg_of = REG_CHAN;
            ADDR_POWER_MODE: reg_of = REG_PWR;
            ADDR_GLOBAL_CLK: reg_of = REG_CLK;
            ADDR_CLK_DIVIDE: reg_of = REG_DIV;
            ADDR_TEST_PATT:  reg_of = REG_TEST;
            ADDR_SELF_TEST:  reg_of = REG_BUILT_IN_SELF_TEST;
            ADDR_OFFSET_ADJ: reg_of = REG_OFFS;
            ADDR_OUT_FORMAT: reg_of = REG_OUT;
            ADDR_CLK_PHASE:  reg_of = REG_PHASE;
            ADDR_UPDATE:     reg_of = REG_UPD;
            default:         reg_of = REG_NONE;
        endcase
    endfunction

    // ****************************************************************
    // Test pattern generators, one per channel
    // ****************************************************************
    // Reset bits act from the active copy, like every other setting
    for (genvar c = 0; c < NCH; c++) begin : g_gen
        acrb_pattern_gen #(
            .DATA_W (DATA_W)
        ) u_gen (
            .core_clk_in  (core_clk_in),
            .reset_n_in   (reset_n_in),
            .test_mode_in (st_r.act.test[c][2:0]),
            .long_rst_in  (st_r.act.test[c][LONG_RST_BIT]),
            .short_rst_in (st_r.act.test[c][SHORT_RST_BIT]),
            .built_in_self_test_en_in   (st_r.act.built_in_self_test[c][BUILT_IN_SELF_TEST_EN_BIT]),
            .built_in_self_test_rst_in  (st_r.act.built_in_self_test[c][BUILT_IN_SELF_TEST_RST_BIT]),
            .pattern_out  (pattern[c])
        );
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        acrb_reg_t         wsel;
        acrb_reg_t         rsel;
        int                rch;
        logic [7:0]        wd;
        logic              pin_act;
        logic [1:0]        mode;
        logic [DATA_W-1:0] v;
        logic [DATA_W-1:0] fmt_v;

        wsel    = reg_of(reg_addr_in);
        rsel    = wsel;
        wd      = reg_wdata_in;
        rch     = 0;
        pin_act = 1'b0;
        mode    = 2'h0;
        v       = '0;
        fmt_v   = '0;
        st_nxt  = st_r;

        // Power-down pin is asynchronous: two stages before use
        st_nxt.pin_meta = pdwn_pin_in;
        st_nxt.pin_sync = st_r.pin_meta;

        // Writes land in the shadow copy only, except the channel index, which acts at once
        if (reg_wr_en_in) begin
            case (wsel)
                REG_CHAN:  st_nxt.chan_sel = wd & MASK_CHAN_INDEX;
                REG_PWR:   st_nxt.sh.pwr_g = wd & MASK_PWR_GLOBAL;
                REG_CLK:   st_nxt.sh.clk   = wd & MASK_GLOBAL_CLK;
                REG_DIV:   st_nxt.sh.div   = wd & MASK_CLK_DIVIDE;
                REG_OUT:   st_nxt.sh.out_g = wd & MASK_OUT_GLOBAL;
                REG_PHASE: st_nxt.sh.phase = wd & MASK_CLK_PHASE;
                default: ;
            endcase

            // Local registers keep one shadow per channel
            for (int c = 0; c < NCH; c++) begin
                if (st_r.chan_sel[c]) begin
                    case (wsel)
                        REG_PWR:  st_nxt.sh.pwr_l[c] = wd & MASK_PWR_LOCAL;
                        REG_TEST: st_nxt.sh.test[c]  = wd & MASK_TEST_PATT;
                        REG_BUILT_IN_SELF_TEST: st_nxt.sh.built_in_self_test[c]  = wd & MASK_SELF_TEST;
                        REG_OFFS: st_nxt.sh.offs[c]  = wd & MASK_OFFSET_ADJ;
                        REG_OUT:  st_nxt.sh.out_l[c] = wd & MASK_OUT_LOCAL;
                        default: ;
                    endcase
                end
            end

            // Transfer is self-clearing, so the update register reads zero
            if (wsel == REG_UPD && wd[XFER_BIT]) begin
                st_nxt.act = st_nxt.sh;
            end
        end

        // Reads return the shadow copy, one cycle after the strobe
        st_nxt.rvalid = reg_rd_en_in;
        if (reg_rd_en_in) begin
            if (!st_r.chan_sel[CHAN_A_BIT] && st_r.chan_sel[CHAN_B_BIT]) begin
                rch = 1;
            end

            case (rsel)
                REG_CHAN:  st_nxt.rdata = st_r.chan_sel;
                REG_PWR:   st_nxt.rdata = st_r.sh.pwr_g | st_r.sh.pwr_l[rch];
                REG_CLK:   st_nxt.rdata = st_r.sh.clk;
                REG_DIV:   st_nxt.rdata = st_r.sh.div;
                REG_TEST:  st_nxt.rdata = st_r.sh.test[rch];
                REG_BUILT_IN_SELF_TEST:  st_nxt.rdata = st_r.sh.built_in_self_test[rch];
                REG_OFFS:  st_nxt.rdata = st_r.sh.offs[rch];
                REG_OUT:   st_nxt.rdata = st_r.sh.out_g | st_r.sh.out_l[rch];
                REG_PHASE: st_nxt.rdata = st_r.sh.phase;
                default:   st_nxt.rdata = RST_ZERO;
            endcase
        end

        // Global clocking and output controls from the active copy
        st_nxt.dcs = st_r.act.clk[DCS_EN_BIT] | (st_r.act.div[2:0] != 3'h0);
        st_nxt.div_sel = st_r.act.div[2:0];
        // Codes above five are not defined; clamp to the longest delay
        st_nxt.div_phase = (st_r.act.phase[2:0] > PHASE_MAX) ?
                           PHASE_MAX : st_r.act.phase[2:0];

        st_nxt.dco_inv = st_r.act.phase[DCO_INV_BIT];
        st_nxt.lvds    = st_r.act.out_g[OUT_TYPE_BIT];
        st_nxt.drive   = st_r.act.out_g[DRIVE_BIT];

        // A powered-down channel drives zeros with its outputs disabled
        pin_act = st_r.pin_sync;
        for (int c = 0; c < NCH; c++) begin
            mode = st_r.act.pwr_l[c][1:0];
            st_nxt.pdwn[c] = (mode == PWR_FULL_DN) ||
                             (pin_act && !st_r.act.pwr_g[PIN_FN_BIT]);
            st_nxt.stby[c] = !st_nxt.pdwn[c] &&
                             ((mode == PWR_STANDBY) ||
                              (pin_act && st_r.act.pwr_g[PIN_FN_BIT]));
            st_nxt.oe_n[c] = st_r.act.out_l[c][OUT_OEB_BIT] | st_nxt.pdwn[c];

            // Offset adjust wraps rather than saturating
            v = sample[c] + {{(DATA_W-OFFSET_W){st_r.act.offs[c][OFFSET_W-1]}},
                             st_r.act.offs[c][OFFSET_W-1:0]};
            if (st_r.act.test[c][2:0] != TEST_OFF || st_r.act.built_in_self_test[c][BUILT_IN_SELF_TEST_EN_BIT]) begin
                v = pattern[c];
            end

            case (st_r.act.out_g[1:0])
                FMT_TWOS_COMP: fmt_v = {~v[DATA_W-1], v[DATA_W-2:0]};
                FMT_GRAY:      fmt_v = v ^ (v >> 1);
                default:       fmt_v = v;
            endcase
            if (st_r.act.out_l[c][OUT_INV_BIT]) begin
                fmt_v = ~fmt_v;
            end

            st_nxt.data[c] = st_nxt.pdwn[c] ? '0 : fmt_v;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r           <= '0;
            st_r.chan_sel  <= RST_CHAN_INDEX;
            st_r.sh        <= CFG_RST;
            st_r.act       <= CFG_RST;
            st_r.dcs       <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata_out       = st_r.rdata;
    assign reg_rdata_valid_out = st_r.rvalid;
    assign ch_a_pdwn_out       = st_r.pdwn[0];
    assign ch_b_pdwn_out       = st_r.pdwn[1];
    assign ch_a_stby_out       = st_r.stby[0];
    assign ch_b_stby_out       = st_r.stby[1];
    assign dcs_active_out      = st_r.dcs;
    assign clk_div_sel_out     = st_r.div_sel;
    assign clk_div_phase_out   = st_r.div_phase;
    assign dco_invert_out      = st_r.dco_inv;
    assign lvds_sel_out        = st_r.lvds;
    assign drive_sel_out       = st_r.drive;
    assign ch_a_oe_n_out       = st_r.oe_n[0];
    assign ch_b_oe_n_out       = st_r.oe_n[1];
    assign ch_a_data_out       = st_r.data[0];
    assign ch_b_data_out       = st_r.data[1];

endmodule

// >>> src/acrb_pkg.sv
package acrb_pkg;

    // ****************************************************************
    // Register addresses (serial port address space)
    // ****************************************************************
    localparam int ADDR_W = 13;

    localparam logic [ADDR_W-1:0] ADDR_CHAN_INDEX  = 13'h0005;
    localparam logic [ADDR_W-1:0] ADDR_POWER_MODE  = 13'h0008;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CLK  = 13'h0009;
    localparam logic [ADDR_W-1:0] ADDR_CLK_DIVIDE  = 13'h000B;
    localparam logic [ADDR_W-1:0] ADDR_TEST_PATT   = 13'h000D;
    localparam logic [ADDR_W-1:0] ADDR_SELF_TEST   = 13'h000E;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_ADJ  = 13'h0010;
    localparam logic [ADDR_W-1:0] ADDR_OUT_FORMAT  = 13'h0014;
    localparam logic [ADDR_W-1:0] ADDR_CLK_PHASE   = 13'h0016;
    localparam logic [ADDR_W-1:0] ADDR_UPDATE      = 13'h00FF;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_CHAN_INDEX = 8'h03;
    localparam logic [7:0] RST_GLOBAL_CLK = 8'h01;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // ****************************************************************
    // Writable bits; everything else reads as zero
    // ****************************************************************
    localparam logic [7:0] MASK_CHAN_INDEX = 8'h03;
    localparam logic [7:0] MASK_PWR_GLOBAL = 8'h20;
    localparam logic [7:0] MASK_PWR_LOCAL  = 8'h03;
    localparam logic [7:0] MASK_GLOBAL_CLK = 8'h01;
    localparam logic [7:0] MASK_CLK_DIVIDE = 8'h07;
    localparam logic [7:0] MASK_TEST_PATT  = 8'h37;
    localparam logic [7:0] MASK_SELF_TEST  = 8'h05;
    localparam logic [7:0] MASK_OFFSET_ADJ = 8'h3F;
    localparam logic [7:0] MASK_OUT_GLOBAL = 8'hC3;
    localparam logic [7:0] MASK_OUT_LOCAL  = 8'h14;
    localparam logic [7:0] MASK_CLK_PHASE  = 8'h87;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CHAN_A_BIT      = 0;
    localparam int CHAN_B_BIT      = 1;
    localparam int PIN_FN_BIT      = 5;
    localparam int DCS_EN_BIT      = 0;
    localparam int LONG_RST_BIT    = 5;
    localparam int SHORT_RST_BIT   = 4;
    localparam int BUILT_IN_SELF_TEST_RST_BIT    = 2;
    localparam int BUILT_IN_SELF_TEST_EN_BIT     = 0;
    localparam int DRIVE_BIT       = 7;
    localparam int OUT_TYPE_BIT    = 6;
    localparam int OUT_OEB_BIT     = 4;
    localparam int OUT_INV_BIT     = 2;
    localparam int DCO_INV_BIT     = 7;
    localparam int XFER_BIT        = 0;
    localparam int OFFSET_W        = 6;
    localparam logic [2:0] PHASE_MAX = 3'h5;

    // ****************************************************************
    // Generator lengths and taps
    // ****************************************************************
    localparam int LONG_LEN  = 23;
    localparam int LONG_TAP  = 17;
    localparam int SHORT_LEN = 9;
    localparam int SHORT_TAP = 4;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        PWR_NORMAL   = 2'h0,
        PWR_FULL_DN  = 2'h1,
        PWR_STANDBY  = 2'h2,
        PWR_NORMAL_B = 2'h3
    } acrb_pwr_t;

    typedef enum logic [2:0] {
        TEST_OFF      = 3'h0,
        TEST_MIDSCALE = 3'h1,
        TEST_POS_FS   = 3'h2,
        TEST_NEG_FS   = 3'h3,
        TEST_CHECKER  = 3'h4,
        TEST_LONG_PRB = 3'h5,
        TEST_SHORT_PR = 3'h6
    } acrb_test_t;

    typedef enum logic [1:0] {
        FMT_OFFSET_BIN = 2'h0,
        FMT_TWOS_COMP  = 2'h1,
        FMT_GRAY       = 2'h2
    } acrb_fmt_t;

    typedef enum logic [3:0] {
        REG_NONE, REG_CHAN, REG_PWR, REG_CLK, REG_DIV, REG_TEST,
        REG_BUILT_IN_SELF_TEST, REG_OFFS, REG_OUT, REG_PHASE, REG_UPD
    } acrb_reg_t;

endpackage

// >>> src/acrb_pattern_gen.sv
`timescale 1ns/100ps

module acrb_pattern_gen
    import acrb_pkg::*;
#(
    parameter int DATA_W = 14
) (
    input  wire logic              core_clk_in,
    input  wire logic              reset_n_in,
    input  wire logic [2:0]        test_mode_in,
    input  wire logic              long_rst_in,
    input  wire logic              short_rst_in,
    input  wire logic              built_in_self_test_en_in,
    input  wire logic              built_in_self_test_rst_in,
    output      logic [DATA_W-1:0] pattern_out
);

    initial begin
        if (DATA_W < 8 || DATA_W > 2 * SHORT_LEN) begin
            $error("acrb_pattern_gen: DATA_W out of range");
        end
    end

    typedef struct packed {
        logic [LONG_LEN-1:0]  long_lfsr;
        logic [SHORT_LEN-1:0] short_lfsr;
        logic                 toggle;
        logic [DATA_W-1:0]    pattern;
    } acrb_gen_state_t;

    acrb_gen_state_t st_r;
    acrb_gen_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.toggle = ~st_r.toggle;
        st_nxt.long_lfsr = {st_r.long_lfsr[LONG_LEN-2:0],
                            st_r.long_lfsr[LONG_LEN-1] ^ st_r.long_lfsr[LONG_TAP]};
        st_nxt.short_lfsr = {st_r.short_lfsr[SHORT_LEN-2:0],
                             st_r.short_lfsr[SHORT_LEN-1] ^ st_r.short_lfsr[SHORT_TAP]};
        // Held at seed while the reset bit stays set
        if (long_rst_in || built_in_self_test_rst_in) begin
            st_nxt.long_lfsr = '1;
        end
        if (short_rst_in) begin
            st_nxt.short_lfsr = '1;
        end
        if (built_in_self_test_en_in) begin
            st_nxt.pattern = st_r.long_lfsr[DATA_W-1:0];
        end else begin
            case (test_mode_in)
                TEST_MIDSCALE: st_nxt.pattern = {1'b1, {(DATA_W-1){1'b0}}};
                TEST_POS_FS:   st_nxt.pattern = '1;
                TEST_NEG_FS:   st_nxt.pattern = '0;
                TEST_CHECKER: begin
                    for (int i = 0; i < DATA_W; i++) begin
                        st_nxt.pattern[i] = (i % 2 == 1) ^ st_r.toggle;
                    end
                end
                TEST_LONG_PRB: st_nxt.pattern = st_r.long_lfsr[DATA_W-1:0];
                TEST_SHORT_PR: st_nxt.pattern = DATA_W'({st_r.short_lfsr, st_r.short_lfsr});
                default:       st_nxt.pattern = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= '{long_lfsr: '1, short_lfsr: '1, toggle: 1'b0, pattern: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pattern_out = st_r.pattern;

endmodule

// >>> verification/acrb_config_bank_properties.sv
`timescale 1ns/100ps
module acrb_config_bank_properties
    import acrb_pkg::*;
(
    input wire logic              core_clk_in,
    input wire logic              reset_n_in,
    input wire logic              reg_wr_en_in,
    input wire logic              reg_rd_en_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0]        reg_rdata_out,
    input wire logic              reg_rdata_valid_out,
    input wire logic              ch_a_pdwn_out,
    input wire logic              ch_a_stby_out,
    input wire logic              ch_a_oe_n_out,
    input wire logic              dcs_active_out,
    input wire logic [2:0]        clk_div_sel_out,
    input wire logic [2:0]        clk_div_phase_out
);
    // ****
    // Bus and configuration relations
    // ****
    logic upd_w;
    assign upd_w = reg_wr_en_in && reg_addr_in == ADDR_UPDATE;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_rd_ans; reg_rd_en_in |=> reg_rdata_valid_out; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_hold; !reg_rd_en_in |=> !reg_rdata_valid_out && $stable(reg_rdata_out); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmapped; reg_rd_en_in && reg_addr_in == 13'h0003 |=> reg_rdata_out == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_upd_zero; reg_rd_en_in && reg_addr_in == ADDR_UPDATE |=> reg_rdata_out == 8'h00; endproperty
    a_upd_zero: assert property (p_upd_zero) else $error("update register not cleared");
    property p_div_dcs; clk_div_sel_out != 3'h0 |-> dcs_active_out; endproperty
    a_div_dcs: assert property (p_div_dcs) else $error("stabilizer off while dividing");
    property p_rst_dcs; $rose(reset_n_in) |-> dcs_active_out; endproperty
    a_rst_dcs: assert property (p_rst_dcs) else $error("stabilizer off after reset");
    property p_phase; clk_div_phase_out <= PHASE_MAX; endproperty
    a_phase: assert property (p_phase) else $error("phase beyond five");
    property p_pwr; ch_a_pdwn_out |-> !ch_a_stby_out && ch_a_oe_n_out; endproperty
    a_pwr: assert property (p_pwr) else $error("power-down state mixed");
    // The divider select may only move two or three edges after a transfer strobe
    property p_apply; $changed(clk_div_sel_out) |-> $past(upd_w, 2) || $past(upd_w, 3); endproperty
    a_apply: assert property (p_apply) else $error("divider moved without transfer");
    c_xfer: cover property (upd_w);
    c_stby: cover property (ch_a_stby_out);
    c_div7: cover property (clk_div_sel_out == 3'h7);
endmodule
bind acrb_config_bank acrb_config_bank_properties i_acrb_config_bank_properties (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_wr_en_in(reg_wr_en_in),
    .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out),
    .reg_rdata_valid_out(reg_rdata_valid_out), .ch_a_pdwn_out(ch_a_pdwn_out),
    .ch_a_stby_out(ch_a_stby_out), .ch_a_oe_n_out(ch_a_oe_n_out), .dcs_active_out(dcs_active_out),
    .clk_div_sel_out(clk_div_sel_out), .clk_div_phase_out(clk_div_phase_out)
);

// >>> verification/acrb_host_model.sv
`timescale 1ns/100ps
module acrb_host_model
    import acrb_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic [7:0]        reg_rdata_in,
    output      logic              reg_wr_en_out,
    output      logic              reg_rd_en_out,
    output      logic [ADDR_W-1:0] reg_addr_out,
    output      logic [7:0]        reg_wdata_out
);
    // ****
    // Host strobes, one byte per access
    // ****
    initial begin
        reg_wr_en_out = 1'b0;
        reg_rd_en_out = 1'b0;
        reg_addr_out = '0;
        reg_wdata_out = '0;
    end
    // Released lines show the inverse, so a stale byte cannot pass unnoticed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        reg_addr_out = ADDR_W'(a);
        reg_wdata_out = d;
        reg_wr_en_out = 1'b1;
        @(negedge core_clk_in);
        reg_wr_en_out = 1'b0;
        reg_addr_out = ~reg_addr_out;
        reg_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_in);
        reg_addr_out = ADDR_W'(a);
        reg_rd_en_out = 1'b1;
        @(negedge core_clk_in);
        d = reg_rdata_in;
        reg_rd_en_out = 1'b0;
        reg_addr_out = ~reg_addr_out;
    endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import acrb_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              wr, rd, pin, vld, a_pd, b_pd, a_sb, b_sb, dcs, data_clock_output, lvds, drv, a_oe_n, b_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wd, rdat;
    logic [2:0]        div, ph;
    logic [13:0]       sa, sb, da, db;
    int                bad_count = 0;
    int                tests_run = 0;
    int                sha[256] = '{default: 0};
    int                shb[256], aca[256], acb[256];
    int                regs[10] = '{5, 8, 9, 11, 13, 14, 16, 20, 22, 255};
    int unsigned       seed = 12;
    always #20 clk = ~clk;
    acrb_host_model i_acrb_host_model (.core_clk_in(clk), .reg_rdata_in(rdat), .reg_wr_en_out(wr),
        .reg_rd_en_out(rd), .reg_addr_out(addr), .reg_wdata_out(wd));
    acrb_config_bank i_acrb_config_bank (.core_clk_in(clk), .reset_n_in(rst_n), .reg_wr_en_in(wr),
        .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd), .pdwn_pin_in(pin),
        .ch_a_sample_in(sa), .ch_b_sample_in(sb), .reg_rdata_out(rdat), .reg_rdata_valid_out(vld),
        .ch_a_pdwn_out(a_pd), .ch_b_pdwn_out(b_pd), .ch_a_stby_out(a_sb), .ch_b_stby_out(b_sb),
        .dcs_active_out(dcs), .clk_div_sel_out(div), .clk_div_phase_out(ph), .dco_invert_out(data_clock_output),
        .lvds_sel_out(lvds), .drive_sel_out(drv), .ch_a_oe_n_out(a_oe_n), .ch_b_oe_n_out(b_oe_n),
        .ch_a_data_out(da), .ch_b_data_out(db));
    // ****
    // Reference model and checks
    // ****
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic put(input int a, input int d);
        int m, k;
        case (a)
            5: m = 16'h0300; 8: m = 16'h2003; 9: m = 16'h0100; 11: m = 16'h0700; 13: m = 16'h0037;
            14: m = 16'h0005; 16: m = 16'h003F; 20: m = 16'hC314; 22: m = 16'h8700; default: m = 0;
        endcase
        i_acrb_host_model.wr(a[7:0], d[7:0]);
        k = (m >> 8) | ((sha[5] & 1) ? m & 255 : 0);
        sha[a] = (sha[a] & ~k) | (d & k);
        k = (m >> 8) | ((shb[5] & 2) ? m & 255 : 0);
        shb[a] = (shb[a] & ~k) | (d & k);
        if (a == 255) begin
            aca = sha;
            acb = shb;
        end
    endtask
    task automatic get(input int a);
        logic [7:0] v;
        i_acrb_host_model.rd(a[7:0], v);
        check("rdata", v, sha[5] == 2 ? shb[a] : sha[a]);
        check("valid", vld, 1'b1);
    endtask
    task automatic chk_ch(input int ac[256], input logic [13:0] s, input logic pd, sb, oe_n,
                          input logic [13:0] dq);
        int m, t, v, p;
        m = ac[8] % 4;
        t = ac[13] % 8;
        p = m == 1 || (pin && (ac[8] >> 5 & 1) == 0);
        check("pdwn", pd, p);
        check("stby", sb, !p && (m == 2 || (pin && (ac[8] >> 5 & 1))));
        check("oe_n", oe_n, (ac[20] >> 4 & 1) | p);
        v = (s + ((ac[16] & 63) ^ 32) - 32) & 16383;
        case (t)
            1: v = 8192; 2: v = 16383; 3: v = 0; 5, 6: v = 16383; default: ;
        endcase
        if ((ac[20] & 3) == 1) v ^= 8192;
        if ((ac[20] & 3) == 2) v ^= v >> 1;
        if (ac[20] >> 2 & 1) v ^= 16383;
        if (p) v = 0;
        // Checkerboard and self-test words move every cycle and are not checked
        if (t != 4 && ac[14] % 2 == 0) check("data", dq, v);
    endtask
    task automatic chk_out();
        check("div", div, aca[11] % 8);
        check("dcs", dcs, aca[9] % 2 | (aca[11] % 8 != 0));
        check("phase", ph, aca[22] % 8 > 5 ? 5 : aca[22] % 8);
        check("dco", data_clock_output, aca[22] >> 7);
        check("lvds", lvds, aca[20] >> 6 & 1);
        check("drive", drv, aca[20] >> 7);
        chk_ch(aca, sa, a_pd, a_sb, a_oe_n, da);
        chk_ch(acb, sb, b_pd, b_sb, b_oe_n, db);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****
    // Stimulus
    // ****
    initial begin
        int t, d;
        {pin, sa, sb} = '0;
        sha[5] = 3;
        sha[9] = 1;
        shb = sha;
        aca = sha;
        acb = sha;
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        foreach (regs[i]) get(regs[i]);
        get(3);
        chk_out();
        for (int n = 0; n < 30; n++) begin
            pin = rnd() % 2;
            sa = 14'(rnd());
            sb = 14'(rnd());
            foreach (regs[i]) begin
                t = rnd() % 7;
                d = regs[i] == 13 ? t | (t == 5 ? 32 : 0) | (t == 6 ? 16 : 0) : rnd() % 256;
                if (regs[i] != 255) put(regs[i], d);
                get(regs[i]);
            end
            put(3, rnd() % 256);
            get(3);
            chk_out();
            put(255, 1);
            repeat (4) @(negedge clk);
            chk_out();
        end
        stop_test();
    end
    // About 1500 cycles of traffic are expected; over six times that is a hang
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
endmodule
